// ==== rtl/adcseq_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH
`define ADCSEQ_CTRL_OFS 8'h00
`define ADCSEQ_TIMING_OFS 8'h04
`define ADCSEQ_RESULT_OFS 8'h08
`define ADCSEQ_IRQ_STAT_OFS 8'h0c
`define ADCSEQ_IRQ_CLR_OFS 8'h10
`define ADCSEQ_IRQ_EN_OFS 8'h14
`define ADCSEQ_ON_BIT 0
`define ADCSEQ_GO_BIT 1
`define ADCSEQ_CHAN_LSB 2
`define ADCSEQ_CLK_LSB 0
`define ADCSEQ_ACQ_LSB 3
`define ADCSEQ_DONE_BIT 0
`define ADCSEQ_CHAN_RST 4'h0
`define ADCSEQ_CLK_RST 3'h0
`define ADCSEQ_ACQ_RST 3'h0
`define ADCSEQ_ACQ_MANUAL 3'h0
`define ADCSEQ_ACQ_TAD_1 5'h02
`define ADCSEQ_ACQ_TAD_2 5'h04
`define ADCSEQ_ACQ_TAD_3 5'h06
`define ADCSEQ_ACQ_TAD_4 5'h08
`define ADCSEQ_ACQ_TAD_5 5'h0c
`define ADCSEQ_ACQ_TAD_6 5'h10
`define ADCSEQ_ACQ_TAD_7 5'h14
`define ADCSEQ_CONV_TADS 5'h0d
`define ADCSEQ_TAD_BASE 7'h02
`define ADCSEQ_SAR_MSB 12'h800
`endif

// ==== rtl/adcseq_core_if.sv ====
// Signals between the sequencer, its bit-period divider and its SAR register.
`timescale 1ns/1ps
`default_nettype none
interface adcseq_core_if;
  import adcseq_pkg::*;
  logic            restart;
  logic [2:0]      clk_sel;
  logic            rc_tick;
  logic            tad_tick;
  logic            sar_start;
  logic            sar_step;
  logic            comp;
  adcseq_code_type dac_code;
  adcseq_code_type decided;
  modport tad_gen (input restart, clk_sel, rc_tick, output tad_tick);
  modport sar (input sar_start, sar_step, comp,
               output dac_code, decided);
  modport ctrl (output restart, clk_sel, rc_tick, sar_start, sar_step,
                comp, input tad_tick, dac_code, decided);
endinterface
`default_nettype wire

// ==== rtl/adcseq_pkg.sv ====
// Types shared by the sequencer modules.
package adcseq_pkg;
  typedef logic [11:0] adcseq_code_type;
  typedef enum logic [1:0] {
    ADCSEQ_SAMPLE = 2'h0,
    ADCSEQ_ACQ    = 2'h1,
    ADCSEQ_CONV   = 2'h3
  } adcseq_state_type;
endpackage

// ==== rtl/adcseq_sar.sv ====
// Successive-approximation register that drives the DAC trial code.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_cfg.svh"
module adcseq_sar
  import adcseq_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Sequencer side.
  adcseq_core_if.sar         core
);
  adcseq_code_type code_r;
  adcseq_code_type code_nxt;
  adcseq_code_type mask_r;
  adcseq_code_type mask_nxt;

  assign core.dac_code = code_r;

  // One result bit per step, most significant first.
  always_comb begin
    core.decided = core.comp ? code_r : (code_r & ~mask_r);
    code_nxt = code_r;
    mask_nxt = mask_r;
    if (core.sar_start) begin
      code_nxt = `ADCSEQ_SAR_MSB;
      mask_nxt = `ADCSEQ_SAR_MSB;
    end else if (core.sar_step) begin
      mask_nxt = mask_r >> 1;
      code_nxt = core.decided | mask_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_r <= 12'h000;
      mask_r <= 12'h000;
    end else begin
      code_r <= code_nxt;
      mask_r <= mask_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/adcseq_tad_gen.sv ====
// Bit-period tick generator: oscillator divider or synchronised RC ticks.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_cfg.svh"
module adcseq_tad_gen
  import adcseq_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Sequencer side.
  adcseq_core_if.tad_gen     core
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [2:0] shift;
  logic [6:0] period;
  logic [5:0] limit;
  logic       div_tick;

  // Codes 000,100,001,101,010,110 give divide by 2,4,8,16,32,64.
  always_comb begin
    shift = {core.clk_sel[1:0], 1'b0} + {2'b00, core.clk_sel[2]};
    period = `ADCSEQ_TAD_BASE << shift;
    limit = 6'(period - 7'h01);
    div_tick = (cnt_r == limit);
    // Code x11 takes the internal RC oscillator instead.
    if (core.clk_sel[1:0] == 2'b11) begin
      core.tad_tick = core.rc_tick;
    end else begin
      core.tad_tick = div_tick;
    end
    // Restart keeps the first divided period whole after the start flag; RC ticks (code x11) are not restarted.
    if (core.restart || div_tick) begin
      cnt_nxt = 6'h00;
    end else begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/adcseq_top.sv ====
// Sequencer for a 12-bit SAR converter with its Avalon-MM register file.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_cfg.svh"
module adcseq_top
  import adcseq_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt.
  output logic             irq_o,
  // Analog front end.
  input  wire logic        comp_i,
  input  wire logic        rc_clk_i,
  output logic             sample_o,
  output logic      [3:0]  channel_o,
  output logic      [11:0] dac_code_o
);
  adcseq_core_if core ();

  // Pin synchronisers and filters.
  logic [1:0] pin_raw;
  logic [2:0] sync_r [2];
  logic [1:0] pin_f_r;
  logic [1:0] pin_f_nxt;
  logic       rc_prev_r;

  // Bus state.
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wr_fire;

  // Control state.
  adcseq_state_type state_r;
  adcseq_state_type state_nxt;
  logic            on_r;
  logic            on_nxt;
  logic            go_r;
  logic            go_nxt;
  logic [3:0]      chan_r;
  logic [3:0]      chan_nxt;
  logic [2:0]      clk_sel_r;
  logic [2:0]      clk_sel_nxt;
  logic [2:0]      acq_sel_r;
  logic [2:0]      acq_sel_nxt;
  logic [4:0]      cnt_r;
  logic [4:0]      cnt_nxt;
  logic [4:0]      acq_tads;
  logic            sample_r;
  logic            sample_nxt;
  adcseq_code_type result_r;
  adcseq_code_type result_nxt;
  logic            stat_r;
  logic            stat_nxt;
  logic            en_r;
  logic            en_nxt;
  logic            irq_r;
  logic            irq_nxt;
  logic            done;
  logic            start;

  assign pin_raw = {rc_clk_i, comp_i};

  // A change counts once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_comb begin
        if (sync_r[g][1] == sync_r[g][2]) begin
          pin_f_nxt[g] = sync_r[g][2];
        end else begin
          pin_f_nxt[g] = pin_f_r[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          sync_r[g] <= 3'h0;
          pin_f_r[g] <= 1'b0;
        end else begin
          sync_r[g] <= {sync_r[g][1:0], pin_raw[g]};
          pin_f_r[g] <= pin_f_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rc_prev_r <= 1'b0;
    end else begin
      rc_prev_r <= pin_f_r[1];
    end
  end

  assign core.rc_tick = pin_f_r[1] & ~rc_prev_r;
  assign core.comp = pin_f_r[0];
  assign core.clk_sel = clk_sel_r;
  assign core.restart = start;

  adcseq_tad_gen u_tad_gen (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .core    (core.tad_gen)
  );

  adcseq_sar u_sar (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .core    (core.sar)
  );

  // Programmed acquisition lengths in bit periods.
  always_comb begin
    unique case (acq_sel_r)
      3'h1: acq_tads = `ADCSEQ_ACQ_TAD_1;
      3'h2: acq_tads = `ADCSEQ_ACQ_TAD_2;
      3'h3: acq_tads = `ADCSEQ_ACQ_TAD_3;
      3'h4: acq_tads = `ADCSEQ_ACQ_TAD_4;
      3'h5: acq_tads = `ADCSEQ_ACQ_TAD_5;
      3'h6: acq_tads = `ADCSEQ_ACQ_TAD_6;
      3'h7: acq_tads = `ADCSEQ_ACQ_TAD_7;
      3'h0: acq_tads = 5'h00;
    endcase
  end

  // Every access waits exactly one cycle, so reads see settled state.
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address_i)
        `ADCSEQ_CTRL_OFS: begin
          rdata_nxt[`ADCSEQ_ON_BIT] = on_r;
          // Only the start flag shows progress.
          rdata_nxt[`ADCSEQ_GO_BIT] = go_r;
          rdata_nxt[`ADCSEQ_CHAN_LSB +: 4] = chan_r;
        end
        `ADCSEQ_TIMING_OFS: begin
          rdata_nxt[`ADCSEQ_CLK_LSB +: 3] = clk_sel_r;
          rdata_nxt[`ADCSEQ_ACQ_LSB +: 3] = acq_sel_r;
        end
        `ADCSEQ_RESULT_OFS: begin
          rdata_nxt[11:0] = result_r;
        end
        `ADCSEQ_IRQ_STAT_OFS: begin
          rdata_nxt[`ADCSEQ_DONE_BIT] = stat_r;
        end
        `ADCSEQ_IRQ_EN_OFS: begin
          rdata_nxt[`ADCSEQ_DONE_BIT] = en_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  assign wr_fire = avs_write_i && !wait_r;

  always_comb begin
    state_nxt = state_r;
    on_nxt = on_r;
    go_nxt = go_r;
    chan_nxt = chan_r;
    clk_sel_nxt = clk_sel_r;
    acq_sel_nxt = acq_sel_r;
    cnt_nxt = cnt_r;
    sample_nxt = sample_r;
    result_nxt = result_r;
    stat_nxt = stat_r;
    en_nxt = en_r;
    start = 1'b0;
    done = 1'b0;
    core.sar_start = 1'b0;
    core.sar_step = 1'b0;
    if (wr_fire) begin
      unique case (avs_address_i)
        `ADCSEQ_CTRL_OFS: begin
          on_nxt = avs_writedata_i[`ADCSEQ_ON_BIT];
          chan_nxt = avs_writedata_i[`ADCSEQ_CHAN_LSB +: 4];
          if (avs_writedata_i[`ADCSEQ_GO_BIT] && on_nxt && !go_r) begin
            start = 1'b1;
          end
        end
        `ADCSEQ_TIMING_OFS: begin
          clk_sel_nxt = avs_writedata_i[`ADCSEQ_CLK_LSB +: 3];
          acq_sel_nxt = avs_writedata_i[`ADCSEQ_ACQ_LSB +: 3];
        end
        `ADCSEQ_IRQ_CLR_OFS: begin
          if (avs_writedata_i[`ADCSEQ_DONE_BIT]) begin
            stat_nxt = 1'b0;
          end
        end
        `ADCSEQ_IRQ_EN_OFS: begin
          en_nxt = avs_writedata_i[`ADCSEQ_DONE_BIT];
        end
        default: begin
          en_nxt = en_r;
        end
      endcase
    end
    unique case (state_r)
      ADCSEQ_SAMPLE: begin
        if (start) begin
          go_nxt = 1'b1;
          cnt_nxt = 5'h00;
          if (acq_sel_r == `ADCSEQ_ACQ_MANUAL) begin
            // Manual mode opens the hold switch at once.
            state_nxt = ADCSEQ_CONV;
            sample_nxt = 1'b0;
            core.sar_start = 1'b1;
          end else begin
            // Keep sampling; the divider restarts with the start.
            state_nxt = ADCSEQ_ACQ;
          end
        end
      end
      ADCSEQ_ACQ: begin
        if (core.tad_tick) begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_nxt == acq_tads) begin
            // Acquisition over; conversion follows on its own.
            state_nxt = ADCSEQ_CONV;
            cnt_nxt = 5'h00;
            sample_nxt = 1'b0;
            core.sar_start = 1'b1;
          end
        end
      end
      ADCSEQ_CONV: begin
        if (core.tad_tick) begin
          // First period disconnects the input, then 12 bit decisions.
          core.sar_step = (cnt_r != 5'h00);
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `ADCSEQ_CONV_TADS - 5'h01) begin
            // Thirteen periods end the conversion.
            done = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ADCSEQ_SAMPLE;
      end
    endcase
    if (done) begin
      state_nxt = ADCSEQ_SAMPLE;
      cnt_nxt = 5'h00;
      go_nxt = 1'b0;
      result_nxt = core.decided;
      sample_nxt = 1'b1;
    end
    // Turning the converter off abandons any conversion in flight.
    if (!on_nxt) begin
      state_nxt = ADCSEQ_SAMPLE;
      go_nxt = 1'b0;
      sample_nxt = 1'b1;
      cnt_nxt = 5'h00;
    end
    // A completion wins over a clear in the same cycle.
    if (done) begin
      stat_nxt = 1'b1;
    end
    irq_nxt = stat_nxt & en_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      state_r <= ADCSEQ_SAMPLE;
      on_r <= 1'b0;
      go_r <= 1'b0;
      chan_r <= `ADCSEQ_CHAN_RST;
      clk_sel_r <= `ADCSEQ_CLK_RST;
      acq_sel_r <= `ADCSEQ_ACQ_RST;
      cnt_r <= 5'h00;
      sample_r <= 1'b1;
      result_r <= 12'h000;
      stat_r <= 1'b0;
      en_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      on_r <= on_nxt;
      go_r <= go_nxt;
      chan_r <= chan_nxt;
      clk_sel_r <= clk_sel_nxt;
      acq_sel_r <= acq_sel_nxt;
      cnt_r <= cnt_nxt;
      sample_r <= sample_nxt;
      result_r <= result_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
    end
  end

  // The comparator passes three synchroniser flops and a filter flop, so the divider must give more than
  // four clocks per bit period; a legal 0.8 us period is sixteen.
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign irq_o = irq_r;
  assign sample_o = sample_r;
  assign channel_o = chan_r;
  assign dac_code_o = core.dac_code;
endmodule
`default_nettype wire

// ==== testbench/adcseq_top_asserts.sv ====
// Checker for the sequencer's bus handshake, sampling and interrupt timing.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top_asserts (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        reset_i,
  // Register bus.
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  // Interrupt and front end.
  input wire logic        irq_o,
  input wire logic        sample_o,
  input wire logic [11:0] dac_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Shadows of bus writes and a count of cycles with sample_o low, since the design's registers are not visible.
  logic [2:0] acq_r;
  logic       en_r;
  logic [9:0] low_r;
  logic       acc_w;
  logic       go_w;
  logic       abort_w;
  assign acc_w = avs_write_i && !avs_waitrequest_o;
  // Clearing the on bit cuts a conversion short, so it is no completion.
  assign abort_w = acc_w && avs_address_i == 8'h00 && !avs_writedata_i[0];
  assign go_w  = acc_w && avs_address_i == 8'h00 && sample_o
                 && avs_writedata_i[1:0] == 2'h3;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acq_r <= 3'h0;
      en_r  <= 1'b0;
      low_r <= 10'h000;
    end else begin
      if (acc_w && avs_address_i == 8'h04) begin
        acq_r <= avs_writedata_i[5:3];
      end
      if (acc_w && avs_address_i == 8'h14) begin
        en_r <= avs_writedata_i[0];
      end
      low_r <= sample_o ? 10'h000 : low_r + 10'h001;
    end
  end
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_manual;
    go_w && acq_r == 3'h0 |=> !sample_o;
  endproperty
  a_manual: assert property (p_manual) else $error("manual start late");
  property p_prog;
    go_w && acq_r != 3'h0 |=> sample_o [*3];
  endproperty
  a_prog: assert property (p_prog) else $error("acquisition cut short");
  property p_conv_len;
    $rose(sample_o) && !$past(abort_w) |-> low_r >= 10'h01a;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");
  property p_done_irq;
    $rose(sample_o) && en_r && !$past(abort_w) |-> ##[0:1] irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no irq at done");
  property p_irq_mask;
    !en_r && !$past(en_r) |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  property p_dac_msb;
    $fell(sample_o) |-> ##[0:1] dac_code_o == 12'h800;
  endproperty
  a_dac_msb: assert property (p_dac_msb) else $error("first trial not msb");
  property p_abort;
    abort_w |=> sample_o;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  c_manual: cover property (go_w && acq_r == 3'h0);
  c_prog: cover property (go_w && acq_r != 3'h0);
  c_irq: cover property ($rose(irq_o));
endmodule
bind adcseq_top adcseq_top_asserts chk_u (.clk_i, .reset_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .irq_o,
  .sample_o, .dac_code_o);
`default_nettype wire

// ==== testbench/tb_adc_acquisition_sequencer.sv ====
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_acquisition_sequencer;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_o;
  logic        comp_i = 1'b0;
  logic        rc_clk_i = 1'b0;
  logic        sample_o;
  logic [3:0]  channel_o;
  logic [11:0] dac_code_o;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t_fall = 0;
  int          t_rise = 0;
  logic        ps = 1'b1;
  logic [31:0] seed = 32'hebd90f27;
  logic [11:0] ana = 12'h000;

  always #25 clk_i = ~clk_i;

  adcseq_top dut_u (.clk_i, .reset_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .irq_o, .comp_i, .rc_clk_i, .sample_o, .channel_o, .dac_code_o);

  // Comparator model, slow RC source and sampling-edge timestamps.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    ps <= sample_o;
    comp_i <= (ana >= dac_code_o);
    if (cyc % 4 == 3) rc_clk_i <= ~rc_clk_i;
    if (ps && !sample_o) t_fall <= cyc;
    if (!ps && sample_o) t_rise <= cyc;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Clocks per bit period for the divider codes.
  function automatic int tad(input logic [2:0] c);
    return 1 << (1 + c[2] + 2 * c[1:0]);
  endfunction

  function automatic int acq_n(input logic [2:0] a);
    int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[a];
  endfunction

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 100) begin
      errors++;
      close_out();
    end
  endtask

  logic [31:0] q;
  logic [2:0]  ck;
  logic [2:0]  aq;
  logic [3:0]  ch;
  int          n;
  int          d;
  int          p;
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    // An unmapped write must leave every place reading zero.
    bus(1'b1, 8'h1c, rnd(), q);
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, a[7:0], 32'h0, q);
      chk("reset read", q, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      q = rnd();
      // Codes 101, 010 and 110 meet the 0.8 us minimum here; faster codes test timing.
      ck = i[2:0];
      ch = q[19:16];
      ana <= q[15:4];
      aq = (i < 2) ? {3{i[0]}} : q[2:0];
      p = (ck[1:0] == 2'h3) ? 8 : tad(ck);
      bus(1'b1, 8'h04, {26'h0, aq, ck}, q);
      bus(1'b0, 8'h04, 32'h0, q);
      chk("timing", q, {26'h0, aq, ck});
      bus(1'b1, 8'h14, {31'h0, i[1]}, q);
      // Select the channel first and let it settle 1.5 us before the start.
      bus(1'b1, 8'h00, {26'h0, ch, 2'h1}, q);
      repeat (30) @(posedge clk_i);
      bus(1'b1, 8'h00, {26'h0, ch, 2'h3}, q);
      n = cyc;
      bus(1'b0, 8'h00, 32'h0, q);
      chk("busy", q[1], 1'b1);
      chk("channel", channel_o, ch);
      d = 0;
      while (t_rise <= n && d < 4000) begin
        @(posedge clk_i);
        d++;
      end
      if (d >= 4000) begin
        errors++;
        close_out();
      end
      d = t_fall - n;
      if (aq == 3'h0) chk("manual start", d, 1);
      else if (p == tad(ck))
        chk("acq window", d >= acq_n(aq) * p && d <= acq_n(aq) * p + 2, 1);
      // RC runs stand for conversions made in Sleep, the clock being fast.
      d = t_rise - t_fall;
      if (p == tad(ck)) chk("conv length", d, 13 * p);
      else chk("rc length", d >= 12 * p && d <= 14 * p, 1);
      // Fast divider codes starve the comparator synchroniser.
      bus(1'b0, 8'h08, 32'h0, q);
      if (p >= 8) chk("result", q, {20'h0, ana});
      bus(1'b0, 8'h00, 32'h0, q);
      chk("go cleared", q[1:0], 2'h1);
      bus(1'b0, 8'h0c, 32'h0, q);
      chk("done flag", q, 32'h1);
      chk("irq level", irq_o, i[1]);
      chk("sampling", sample_o, 1'b1);
      bus(1'b1, 8'h10, 32'h1, q);
      bus(1'b0, 8'h0c, 32'h0, q);
      chk("done cleared", q, 32'h0);
      chk("irq cleared", irq_o, 1'b0);
      $display("test conversion %0d done", i);
    end
    // Clearing the on bit mid-conversion abandons it and resumes sampling.
    bus(1'b1, 8'h04, 32'h0000_0002, q);
    bus(1'b1, 8'h00, 32'h0000_0001, q);
    repeat (30) @(posedge clk_i);
    bus(1'b1, 8'h00, 32'h0000_0003, q);
    bus(1'b0, 8'h00, 32'h0, q);
    chk("abort busy", q, 32'h3);
    bus(1'b1, 8'h00, 32'h0000_0000, q);
    bus(1'b0, 8'h00, 32'h0, q);
    chk("abort ctrl", q, 32'h0);
    chk("abort sampling", sample_o, 1'b1);
    bus(1'b0, 8'h0c, 32'h0, q);
    chk("abort no done", q, 32'h0);
    $display("test abort done");
    close_out();
  end
endmodule
`default_nettype wire
